// ---- src/macs_ctrl.sv ----
// clock source, speed range and status indicator control
// assumes link-domain flags arrive on i_link_clk; panel buttons are
// debounced single-cycle pulses on i_sys_clk; settings store is external
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// RULE1 - madi sync steady, flash unsynced, error missing
// RULE2 - madi pair audio led on nonzero sample
// RULE3 - flag received 64-channel and 96k frame
// RULE4 - tx offers 56/64 channels, 96k only double
// RULE5 - valid aes input flashes sync when unsynchronous
// RULE6 - aes double and quad speed rate indicators
// RULE7 - aes audio led on any nonzero channel
// RULE8 - clock source steps aes madi word 44.1 48
// RULE9 - slave reference missing flashes its led
// RULE10 - aes reference is lowest valid input
// RULE11 - master rate scaled by speed range
// RULE12 - sources must sync to our outputs
// RULE13 - single speed outputs 32 to 48 khz
// RULE14 - double: aes 1-16, madi 2x mux or 96k
// RULE15 - quad: aes 1-8, madi 4x mux only
// RULE16 - process aes inputs 1-16 ds, 1-8 qs
// RULE17 - follow mode derives range, not from madi
// RULE18 - speed press during version toggles follow
// RULE19 - madi failover in one second, led blinking
// RULE20 - default channel status fields, emphasis dropped
// RULE21 - transparent mode copies odd channel status
// RULE22 - transparent mode set by power-on buttons
// RULE23 - settings restored at power-on
// RULE24 - one common flash rate for all indicators
module macs_ctrl #(
  parameter int N_AES = macs_pkg::AES_INPUTS,
  parameter int FLASH_CYC = macs_pkg::FLASH_HALF_CYC,
  parameter int FAIL_CYC = macs_pkg::FAILOVER_CYC
) (
  // system clock and reset
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  // link (audio sample) clock domain
  input wire logic i_link_clk,
  input wire logic [N_AES-1:0] i_aes_valid,      // per aes input, link domain
  input wire logic [N_AES-1:0] i_aes_sync,       // per aes input synchronous
  input wire logic [N_AES-1:0] i_aes_nonzero,    // per aes input sample nonzero
  input wire logic [1:0] i_madi_valid,           // per madi port signal valid
  input wire logic i_madi_sync,                  // active madi synchronous
  input wire logic [31:0] i_madi_pair_nonzero,   // per madi pair nonzero
  input wire logic i_madi_rx_ch64,               // received 64-channel
  input wire logic i_madi_rx_frame96,            // received 96k frame
  input wire logic i_word_valid,                 // word clock reference valid
  // measured reference and aes rates in hz (system domain, stable)
  input wire logic [17:0] i_ref_rate_hz,
  input wire logic [17:0] i_aes_rate_hz,
  // panel events, one-cycle button pulses; i_version_shown is a level
  input wire logic i_btn_clock,
  input wire logic i_btn_speed,
  input wire logic i_btn_frame,
  input wire logic i_btn_format,
  input wire logic i_btn_input,
  input wire logic i_version_shown,
  // power-on button straps and stored settings
  input wire logic i_strap_aes_hold,
  input wire logic i_strap_remote_hold,
  input wire logic i_restore,                    // pulse: load stored settings
  input wire logic [2:0] i_stored_src,
  input wire logic [1:0] i_stored_speed,
  input wire logic [1:0] i_stored_madi_fmt,
  input wire logic i_stored_follow,
  // madi indicators
  output logic o_madi_sync_led,
  output logic o_madi_err_led,
  output logic [31:0] o_madi_audio_led,
  output logic o_madi_ch64_led,
  output logic o_madi_frame96_led,
  output logic [1:0] o_madi_input_led,
  output logic o_madi_active_port,
  // aes indicators
  output logic [N_AES-1:0] o_aes_sync_led,
  output logic [N_AES-1:0] o_aes_audio_led,
  output logic o_aes_ds_led,
  output logic o_aes_qs_led,
  output logic [N_AES-1:0] o_aes_enable,
  // clock section
  output logic [2:0] o_clk_src,
  output logic [4:0] o_clk_src_led,
  output logic o_master_mode,
  output logic [4:0] o_aes_ref_index,
  output logic [1:0] o_speed,
  output logic o_ds_led,
  output logic o_qs_led,
  output logic o_follow,
  // madi output format and channel status
  output logic [3:0] o_madi_fmt,
  output logic [10:0] o_cstat,
  output logic o_transparent,
  output logic o_remote_via_madi,
  output logic [2:0] o_settings           // src for the settings store
);

  initial begin
    if (N_AES < 8 || N_AES > 32) $error("N_AES out of range");
    if (FLASH_CYC < 2 || FAIL_CYC < 2) $error("counts too small");
  end

  // -- link to system crossing: two flops per level
  localparam int NL = 3 * N_AES + 2 + 1 + 32 + 2 + 1;
  logic [NL-1:0] lk_q;   // link-domain register of raw flags
  logic [NL-1:0] s1_q;   // first sync stage
  logic [NL-1:0] s2_q;   // second sync stage

  // capture flags on the link clock
  always_ff @(posedge i_link_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lk_q <= '0;
    end else begin
      lk_q <= {i_aes_valid, i_aes_sync, i_aes_nonzero, i_madi_valid, i_madi_sync,
               i_madi_pair_nonzero, i_madi_rx_ch64, i_madi_rx_frame96, i_word_valid};
    end
  end

  // two-flop synchroniser into the system clock
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= lk_q;
      s2_q <= s1_q;
    end
  end

  // unpack synchronised flags
  logic [N_AES-1:0] aes_valid, aes_sync, aes_nz;
  logic [1:0] madi_valid;
  logic madi_sync, rx64, rx96, word_valid;
  logic [31:0] madi_nz;
  assign {aes_valid, aes_sync, aes_nz, madi_valid, madi_sync,
          madi_nz, rx64, rx96, word_valid} = s2_q;

  // -- common flash generator
  logic [31:0] flash_cnt_q;
  logic flash_q;     // flash phase shared by all indicators
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      flash_cnt_q <= '0;
      flash_q <= 1'b0;
    end else if (flash_cnt_q == 32'(FLASH_CYC - 1)) begin
      flash_cnt_q <= '0;
      flash_q <= ~flash_q; // RULE24
    end else begin
      flash_cnt_q <= flash_cnt_q + 32'h1;
    end
  end

  // rate window test
  function automatic logic in_win(input logic [17:0] r, input int lo, input int hi);
    in_win = (int'(r) >= lo) && (int'(r) <= hi);
  endfunction

  // lowest valid aes input
  function automatic logic [5:0] lowest(input logic [N_AES-1:0] v);
    lowest = 6'h3F;
    for (int i = N_AES - 1; i >= 0; i--) begin
      if (v[i]) lowest = 6'(i);
    end
  endfunction

  // -- settings
  logic [2:0] src_q;
  logic [1:0] speed_q;
  logic follow_q, ch64_q, f96_q, transp_q, port_q, strap_done_q;
  logic master;
  assign master = (src_q == macs_pkg::MACS_SRC_INT441) || (src_q == macs_pkg::MACS_SRC_INT48);

  // follow mode range from measured reference rate
  logic [1:0] follow_speed;
  always_comb begin
    if (in_win(i_ref_rate_hz, macs_pkg::QS_LO_HZ, macs_pkg::QS_HI_HZ)) begin
      follow_speed = macs_pkg::MACS_SPD_QUAD;
    end else if (in_win(i_ref_rate_hz, macs_pkg::DS_LO_HZ, macs_pkg::DS_HI_HZ)) begin
      follow_speed = macs_pkg::MACS_SPD_DOUBLE;
    end else begin
      follow_speed = macs_pkg::MACS_SPD_SINGLE;
    end
  end

  // clock source stepping
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      src_q <= macs_pkg::CLK_SRC_RST;
    end else if (i_restore) begin
      src_q <= (i_stored_src > 3'h4) ? macs_pkg::CLK_SRC_RST : i_stored_src; // RULE23
    end else if (i_btn_clock) begin
      src_q <= (src_q == macs_pkg::MACS_SRC_INT48) ? 3'h0 : src_q + 3'h1; // RULE8
    end
  end

  // speed range: manual, or followed from aes/word reference
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      speed_q <= macs_pkg::SPEED_RST;
    end else if (i_restore) begin
      speed_q <= (i_stored_speed == 2'h3) ? macs_pkg::SPEED_RST : i_stored_speed; // RULE23
    end else if (follow_q && (src_q == macs_pkg::MACS_SRC_AES
                              || src_q == macs_pkg::MACS_SRC_WORD)) begin
      speed_q <= follow_speed; // RULE17
    end else if (i_btn_speed && !i_version_shown) begin
      speed_q <= (speed_q == macs_pkg::MACS_SPD_QUAD) ? 2'h0 : speed_q + 2'h1; // RULE11
    end
  end

  // follow toggle, madi format buttons
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      follow_q <= 1'b0;
      ch64_q <= 1'b0;
      f96_q <= 1'b0;
    end else if (i_restore) begin
      follow_q <= i_stored_follow; // RULE23
      ch64_q <= i_stored_madi_fmt[1];
      f96_q <= i_stored_madi_fmt[0];
    end else begin
      if (i_btn_speed && i_version_shown) follow_q <= ~follow_q; // RULE18
      if (i_btn_format) ch64_q <= ~ch64_q; // RULE4
      if (i_btn_frame) f96_q <= ~f96_q; // RULE4
    end
  end

  // transparent mode caught after reset release from power-on straps
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      transp_q <= 1'b0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      if (i_strap_aes_hold) transp_q <= 1'b1; // RULE22
      else if (i_strap_remote_hold) transp_q <= 1'b0; // RULE22
    end
  end

  // -- madi input redundancy
  logic [31:0] fail_cnt_q;
  logic switched_q;   // failover has occurred
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      port_q <= 1'b0;
      fail_cnt_q <= '0;
      switched_q <= 1'b0;
    end else if (!madi_valid[port_q] && madi_valid[~port_q]
                 && fail_cnt_q == 32'(FAIL_CYC - 1)) begin
      // failover wins over a manual press in the same cycle
      port_q <= ~port_q; // RULE19
      fail_cnt_q <= '0;
      switched_q <= 1'b1;
    end else if (i_btn_input) begin
      // manual choice clears the failover marker
      port_q <= ~port_q;
      fail_cnt_q <= '0;
      switched_q <= 1'b0;
    end else if (!madi_valid[port_q] && madi_valid[~port_q]) begin
      fail_cnt_q <= fail_cnt_q + 32'h1;
    end else begin
      fail_cnt_q <= '0;
    end
  end

  // -- madi indicators
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_madi_sync_led <= 1'b0;
      o_madi_err_led <= 1'b0;
      o_madi_audio_led <= '0;
      o_madi_ch64_led <= 1'b0;
      o_madi_frame96_led <= 1'b0;
      o_madi_input_led <= '0;
      o_madi_active_port <= 1'b0;
    end else begin
      o_madi_sync_led <= madi_valid[port_q] & (madi_sync | flash_q); // RULE1
      o_madi_err_led <= ~madi_valid[port_q]; // RULE1
      o_madi_audio_led <= madi_nz & {32{madi_valid[port_q]}}; // RULE2
      o_madi_ch64_led <= madi_valid[port_q] & rx64; // RULE3
      o_madi_frame96_led <= madi_valid[port_q] & rx96; // RULE3
      o_madi_active_port <= port_q;
      o_madi_input_led[port_q] <= 1'b1; // RULE19
      o_madi_input_led[~port_q] <= switched_q & flash_q; // RULE19
    end
  end

  // aes inputs enabled by speed range
  logic [N_AES-1:0] aes_en;
  always_comb begin
    for (int i = 0; i < N_AES; i++) begin
      case (speed_q)
        macs_pkg::MACS_SPD_DOUBLE: aes_en[i] = (i < macs_pkg::AES_DS_INPUTS); // RULE16
        macs_pkg::MACS_SPD_QUAD: aes_en[i] = (i < macs_pkg::AES_QS_INPUTS); // RULE16
        default: aes_en[i] = 1'b1; // RULE13
      endcase
    end
  end

  // -- aes indicators and outputs enable
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_aes_sync_led <= '0;
      o_aes_audio_led <= '0;
      o_aes_ds_led <= 1'b0;
      o_aes_qs_led <= 1'b0;
      o_aes_enable <= '0;
    end else begin
      o_aes_sync_led <= aes_valid & (aes_sync | {N_AES{flash_q}}); // RULE5
      o_aes_audio_led <= aes_valid & aes_nz; // RULE7
      o_aes_ds_led <= in_win(i_aes_rate_hz, macs_pkg::DS_LO_HZ, macs_pkg::DS_HI_HZ); // RULE6
      o_aes_qs_led <= in_win(i_aes_rate_hz, macs_pkg::QS_LO_HZ, macs_pkg::QS_HI_HZ); // RULE6
      o_aes_enable <= aes_en; // RULE14
    end
  end

  // reference validity and source leds
  logic ref_ok;
  logic [5:0] low_idx;
  assign low_idx = lowest(aes_valid);
  always_comb begin
    case (src_q)
      macs_pkg::MACS_SRC_AES: ref_ok = |aes_valid;
      macs_pkg::MACS_SRC_MADI: ref_ok = madi_valid[port_q];
      macs_pkg::MACS_SRC_WORD: ref_ok = word_valid;
      default: ref_ok = 1'b1;
    endcase
  end

  // -- clock section outputs
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_clk_src <= macs_pkg::CLK_SRC_RST;
      o_clk_src_led <= '0;
      o_master_mode <= 1'b0;
      o_aes_ref_index <= '0;
      o_speed <= macs_pkg::SPEED_RST;
      o_ds_led <= 1'b0;
      o_qs_led <= 1'b0;
      o_follow <= 1'b0;
    end else begin
      o_clk_src <= src_q;
      o_clk_src_led <= '0;
      o_clk_src_led[src_q] <= ref_ok | flash_q; // RULE9
      if (i_version_shown) o_clk_src_led[0] <= transp_q; // RULE22
      o_master_mode <= master; // RULE12
      if (low_idx != 6'h3F) o_aes_ref_index <= low_idx[4:0]; // RULE10
      o_speed <= speed_q;
      o_ds_led <= i_version_shown ? follow_q : (speed_q == macs_pkg::MACS_SPD_DOUBLE); // RULE18
      o_qs_led <= i_version_shown ? follow_q : (speed_q == macs_pkg::MACS_SPD_QUAD); // RULE18
      o_follow <= follow_q;
    end
  end

  // sample rate code from source and range
  logic [3:0] rate_code;
  always_comb begin
    rate_code = {speed_q, 1'b0, (src_q == macs_pkg::MACS_SRC_INT48)}; // RULE11
    if (!master) rate_code = {speed_q, 2'h2};
  end

  // -- madi format and channel status
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_madi_fmt <= '0;
      o_cstat <= '0;
      o_transparent <= 1'b0;
      o_remote_via_madi <= 1'b0;
      o_settings <= macs_pkg::CLK_SRC_RST;
    end else begin
      // 96k framing only in double speed; never with multiplexing
      o_madi_fmt <= {ch64_q, f96_q && speed_q == macs_pkg::MACS_SPD_DOUBLE, // RULE4
                     speed_q == macs_pkg::MACS_SPD_DOUBLE && !f96_q, // RULE14
                     speed_q == macs_pkg::MACS_SPD_QUAD}; // RULE15
      o_cstat <= {rate_code, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1}; // RULE20
      o_transparent <= transp_q; // RULE21
      o_remote_via_madi <= ~transp_q; // RULE21
      o_settings <= src_q;
    end
  end

endmodule // macs_ctrl

`default_nettype wire

// ---- src/macs_pkg.sv ----
// package for the madi/aes clock and status control block
// assumes a 25 mhz system clock and a sampled link (audio) clock domain
package macs_pkg;

  // system clock period in ns
  localparam int SYS_CLK_NS = 40;
  // flash half period of indicators, in ms
  localparam int FLASH_HALF_MS = 250;
  localparam int FLASH_HALF_CYC = (FLASH_HALF_MS * 1000000) / SYS_CLK_NS;
  // madi failover time, in ms (about one second)
  localparam int FAILOVER_MS = 1000;
  localparam int FAILOVER_CYC = (FAILOVER_MS * 1000000) / SYS_CLK_NS;

  // rate thresholds in hz
  localparam int DS_LO_HZ = 60000;
  localparam int DS_HI_HZ = 100000;
  localparam int QS_LO_HZ = 162000;
  localparam int QS_HI_HZ = 200000;
  localparam int FB96_LO_HZ = 64000;
  localparam int FB96_HI_HZ = 96000;

  // counts of inputs
  localparam int AES_INPUTS = 32;
  localparam int MADI_PAIRS = 32;
  localparam int AES_DS_INPUTS = 16;
  localparam int AES_QS_INPUTS = 8;

  // reset values
  localparam logic [2:0] CLK_SRC_RST = 3'h3;
  localparam logic [1:0] SPEED_RST = 2'h0;

  // clock source selection, stepped in this order
  typedef enum logic [2:0] {
    MACS_SRC_AES = 3'b000,
    MACS_SRC_MADI = 3'b001,
    MACS_SRC_WORD = 3'b010,
    MACS_SRC_INT441 = 3'b011,
    MACS_SRC_INT48 = 3'b100
  } macs_src_t;

  // speed range
  typedef enum logic [1:0] {
    MACS_SPD_SINGLE = 2'b00,
    MACS_SPD_DOUBLE = 2'b01,
    MACS_SPD_QUAD = 2'b10
  } macs_speed_t;

  // channel status fields carried as one struct
  typedef struct packed {
    logic [3:0] rate_code;   // current sample rate code
    logic aux_24bit;         // aux bits audio use, 24 bit
    logic two_channel;       // 2-channel mode
    logic emphasis;          // always none
    logic general_cat;       // category general
    logic copy_ok;           // copy permitted
    logic audio_use;         // audio use
    logic professional;      // professional format
  } macs_cstat_t;

  // madi output format
  typedef struct packed {
    logic ch64;         // 64-channel format
    logic frame96;      // 96k framing
    logic smux2;        // 2x multiplex
    logic smux4;        // 4x multiplex
  } macs_madi_fmt_t;

endpackage : macs_pkg

// ---- tb/macs_far_end.sv ----
// far-end model: audio sources and madi links feeding the status flags
// assumes the bench sets the wanted levels; they appear on the link clock
`timescale 1ns/10ps
`default_nettype none
module macs_far_end (
  // link clock and wanted levels
  input wire logic i_link_clk,
  input wire logic [31:0] i_valid,
  input wire logic [31:0] i_nonzero,
  input wire logic [1:0] i_madi_valid,
  // flags toward the device
  output logic [31:0] o_aes_valid,
  output logic [31:0] o_aes_sync,
  output logic [31:0] o_aes_nonzero,
  output logic [1:0] o_madi_valid,
  output logic o_madi_sync
);
  // sources are slaved to our outputs, so a live source is in sync
  always_ff @(posedge i_link_clk) begin
    o_aes_valid <= i_valid;
    o_aes_sync <= i_valid;
    o_aes_nonzero <= i_nonzero;
    o_madi_valid <= i_madi_valid;
    o_madi_sync <= |i_madi_valid;
  end
endmodule // macs_far_end
`default_nettype wire

// ---- tb/macs_ctrl_assertions.sv ----
// concurrent checks on the clock and status control ports
// assumes one system clock domain and the active-low async reset
`timescale 1ns/10ps
`default_nettype none
module macs_ctrl_assertions #(
  parameter int N_AES = 32
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  // watched inputs
  input wire logic [1:0] i_madi_valid,
  input wire logic [17:0] i_aes_rate_hz,
  input wire logic i_btn_clock,
  input wire logic i_btn_speed,
  input wire logic i_version_shown,
  // watched outputs
  input wire logic o_madi_err_led,
  input wire logic o_aes_ds_led,
  input wire logic o_aes_qs_led,
  input wire logic [N_AES-1:0] o_aes_enable,
  input wire logic [2:0] o_clk_src,
  input wire logic o_master_mode,
  input wire logic [1:0] o_speed,
  input wire logic o_follow,
  input wire logic [3:0] o_madi_fmt,
  input wire logic [10:0] o_cstat,
  input wire logic o_transparent
);
  logic [3:0] cnt_q; // cycles since reset release, saturating
  logic up; // outputs have settled after reset
  // settle counter, restarted by every reset
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_q <= 4'h0;
    end else if (cnt_q != 4'hF) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  assign up = (cnt_q == 4'hF);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_arst_n);
  // clock press while on the last internal source
  sequence s_step_wrap;
    up && i_btn_clock && o_clk_src == 3'h4;
  endsequence
  // speed range held for two cycles
  sequence s_speed_held(logic [1:0] spd);
    (up && $stable(o_speed) && o_speed == spd)[*2];
  endsequence
  a_src_wrap: assert property (s_step_wrap |-> ##[1:3] o_clk_src == 3'h0)
    else $error("clock source did not wrap to aes");
  a_master_mode: assert property ((up && $stable(o_clk_src))[*3] |->
    o_master_mode == (o_clk_src >= 3'h3))
    else $error("master mode does not match source");
  a_follow_on: assert property (up && i_btn_speed && i_version_shown && !o_follow
    |-> ##[1:3] o_follow)
    else $error("follow mode not entered");
  a_cstat_fixed: assert property (up && !o_transparent |-> o_cstat[6:0] == 7'h6F)
    else $error("default channel status wrong");
  a_frame96_ds: assert property ((up && $stable(o_speed) && o_madi_fmt[2])[*2] |->
    o_speed == 2'h1)
    else $error("96k frame outside double speed");
  a_quad_mux: assert property (s_speed_held(2'h2) |-> o_madi_fmt[0] && !o_madi_fmt[2])
    else $error("quad speed madi format wrong");
  a_quad_inputs: assert property (s_speed_held(2'h2) |-> (o_aes_enable >> 8) == '0)
    else $error("aes input above 8 enabled in quad");
  a_rate_ds: assert property ((up && $stable(i_aes_rate_hz) && i_aes_rate_hz > macs_pkg::DS_LO_HZ
    && i_aes_rate_hz < macs_pkg::DS_HI_HZ)[*3] |-> o_aes_ds_led && !o_aes_qs_led)
    else $error("double speed rate not flagged");
  a_rate_qs: assert property ((up && $stable(i_aes_rate_hz) && i_aes_rate_hz > macs_pkg::QS_LO_HZ
    && i_aes_rate_hz < macs_pkg::QS_HI_HZ)[*3] |-> o_aes_qs_led && !o_aes_ds_led)
    else $error("quad speed rate not flagged");
  a_madi_err: assert property ((up && i_madi_valid == 2'h0)[*8] |-> ##[0:8] o_madi_err_led)
    else $error("madi error led not lit");
endmodule // macs_ctrl_assertions
bind macs_ctrl macs_ctrl_assertions #(.N_AES(N_AES)) u_macs_chk (.i_sys_clk, .i_arst_n,
  .i_madi_valid, .i_aes_rate_hz, .i_btn_clock, .i_btn_speed, .i_version_shown,
  .o_madi_err_led, .o_aes_ds_led, .o_aes_qs_led, .o_aes_enable, .o_clk_src, .o_master_mode,
  .o_speed, .o_follow, .o_madi_fmt, .o_cstat, .o_transparent);
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the clock and status control block
// assumes the far-end model drives link flags on a 160 ns link clock
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk, lclk, rst_n; // clocks and reset
  logic [31:0] want_valid, want_nz, madi_nz; // wanted source levels
  logic [1:0] want_madi;
  logic ch64, fr96, word_ok, ver, strap_aes, strap_rem, restore;
  logic [4:0] btn; // clock speed frame format input
  logic [17:0] ref_hz, aes_hz;
  logic [2:0] st_src;
  logic [1:0] st_spd;
  logic [31:0] aes_valid, aes_sync, aes_nz, madi_audio, aes_sync_led, aes_audio, aes_en;
  logic [1:0] madi_valid, spd;
  logic madi_sync, madi_sync_led, madi_err_led, ch64_led, fr96_led, aes_ds, aes_qs;
  logic master, follow, transp, remote;
  logic mport, ds_led, qs_led; // active madi port and range leds
  logic [1:0] in_led; // madi input leds
  logic [2:0] settings; // value for the settings store
  logic [2:0] src;
  logic [4:0] ref_idx, clk_led;
  logic [3:0] fmt;
  logic [10:0] cstat;
  logic [17:0] hz_tab [3] = '{18'h17700, 18'h2EE00, 18'h0BB80}; // 96k 192k 48k
  int fails, checks, cyc;
  // system clock, 25 mhz
  always #20 clk = ~clk;
  // link clock, 160 ns, phase unrelated
  initial begin
    lclk = 1'b0;
    #13;
    forever #80 lclk = ~lclk;
  end
  macs_far_end u_far (.i_link_clk(lclk), .i_valid(want_valid), .i_nonzero(want_nz),
    .i_madi_valid(want_madi), .o_aes_valid(aes_valid), .o_aes_sync(aes_sync),
    .o_aes_nonzero(aes_nz), .o_madi_valid(madi_valid), .o_madi_sync(madi_sync));
  macs_ctrl #(.N_AES(32), .FLASH_CYC(4), .FAIL_CYC(16)) DUT (.i_sys_clk(clk), .i_arst_n(rst_n),
    .i_link_clk(lclk), .i_aes_valid(aes_valid), .i_aes_sync(aes_sync), .i_aes_nonzero(aes_nz),
    .i_madi_valid(madi_valid), .i_madi_sync(madi_sync), .i_madi_pair_nonzero(madi_nz),
    .i_madi_rx_ch64(ch64), .i_madi_rx_frame96(fr96), .i_word_valid(word_ok),
    .i_ref_rate_hz(ref_hz), .i_aes_rate_hz(aes_hz), .i_btn_clock(btn[0]), .i_btn_speed(btn[1]),
    .i_btn_frame(btn[2]), .i_btn_format(btn[3]), .i_btn_input(btn[4]), .i_version_shown(ver),
    .i_strap_aes_hold(strap_aes), .i_strap_remote_hold(strap_rem), .i_restore(restore),
    .i_stored_src(st_src), .i_stored_speed(st_spd), .i_stored_madi_fmt(2'h0),
    .i_stored_follow(1'b0), .o_madi_sync_led(madi_sync_led), .o_madi_err_led(madi_err_led),
    .o_madi_audio_led(madi_audio), .o_madi_ch64_led(ch64_led), .o_madi_frame96_led(fr96_led),
    .o_madi_input_led(in_led), .o_madi_active_port(mport), .o_aes_sync_led(aes_sync_led),
    .o_aes_audio_led(aes_audio), .o_aes_ds_led(aes_ds), .o_aes_qs_led(aes_qs),
    .o_aes_enable(aes_en), .o_clk_src(src), .o_clk_src_led(clk_led), .o_master_mode(master),
    .o_aes_ref_index(ref_idx), .o_speed(spd), .o_ds_led(ds_led), .o_qs_led(qs_led),
    .o_follow(follow),
    .o_madi_fmt(fmt), .o_cstat(cstat), .o_transparent(transp), .o_remote_via_madi(remote),
    .o_settings(settings));
  // compare one observed value with its expectation
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // print the verdict and stop
  task automatic tally_and_finish;
    if (fails == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // wait a number of falling edges
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one-cycle panel press, then let outputs settle
  task automatic press(input int b);
    btn[b] = 1'b1;
    @(negedge clk);
    btn = '0;
    wait_cyc(5);
  endtask
  // reset held three cycles, then settle
  task automatic do_reset;
    rst_n = 1'b0;
    wait_cyc(3);
    rst_n = 1'b1;
    wait_cyc(3);
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      tally_and_finish();
    end
  end
  // main sequence
  initial begin
    int n;
    logic prev;
    clk = 1'b0; rst_n = 1'b0; btn = '0; want_valid = '0; want_nz = '0; madi_nz = '0;
    want_madi = 2'h0; ch64 = 1'b0; fr96 = 1'b0; word_ok = 1'b1; ver = 1'b0; restore = 1'b0;
    strap_aes = 1'b0; strap_rem = 1'b0; ref_hz = '0; aes_hz = '0; st_src = 3'h2; st_spd = 2'h1;
    do_reset();
    chk(src, 32'h3);
    chk(cstat[6:0], 32'h6F);
    for (int i = 0; i < 5; i++) begin
      press(0);
      chk(src, (4 + i) % 5);
      chk(master, ((4 + i) % 5) >= 3);
    end
    press(1);
    chk(spd, 32'h1);
    chk(aes_en, 32'h0000_FFFF);
    press(2);
    chk(fmt[2:1], 32'h2);
    press(1);
    chk(spd, 32'h2);
    chk(fmt, 32'h1);
    chk(aes_en[31:8], 32'h0);
    press(2);
    chk(fmt[2], 32'h0);
    press(1);
    chk(fmt[2:0], 32'h0);
    press(3);
    chk(fmt[3], 32'h1);
    want_valid = 32'h28; want_nz = 32'h0000_0020; want_madi = 2'h3; madi_nz = 32'h100; ch64 = 1'b1;
    wait_cyc(20);
    press(0);
    press(0);
    chk(ref_idx, 32'h3);
    chk(aes_sync_led, 32'h28);
    chk(aes_audio, 32'h0000_0020);
    chk(madi_audio, 32'h100);
    chk({ch64_led, fr96_led}, 32'h2);
    chk({madi_sync_led, madi_err_led}, 32'h2);
    want_valid = '0;
    want_madi = 2'h0;
    wait_cyc(20);
    chk(madi_err_led, 32'h1);
    n = 0;
    for (int i = 0; i < 16; i++) begin
      prev = clk_led[0];
      @(negedge clk);
      if (clk_led[0] !== prev) n++;
    end
    chk(n >= 2, 32'h1);
    for (int i = 0; i < 3; i++) begin
      aes_hz = hz_tab[i];
      wait_cyc(4);
      chk({aes_ds, aes_qs}, 2 - i);
    end
    want_valid = 32'h28;
    ver = 1'b1;
    press(1);
    chk(follow, 32'h1);
    chk({ds_led, qs_led}, 32'h3);
    ver = 1'b0;
    ref_hz = 18'h2EE00;
    wait_cyc(20);
    chk(spd, 32'h2);
    chk({ds_led, qs_led}, 32'h1);
    restore = 1'b1;
    @(negedge clk);
    restore = 1'b0;
    wait_cyc(4);
    chk({src, spd}, 32'h9);
    chk(settings, 32'h2);
    // active madi port fails while the other one stays live
    want_madi = 2'h2;
    wait_cyc(10);
    chk(mport, 32'h0);
    wait_cyc(30);
    chk({mport, in_led[1]}, 32'h3);
    chk(madi_err_led, 32'h0);
    n = 0;
    for (int i = 0; i < 16; i++) begin
      prev = in_led[0];
      @(negedge clk);
      if (in_led[0] !== prev) n++;
    end
    chk(n >= 2, 32'h1);
    strap_aes = 1'b1;
    do_reset();
    chk({transp, remote}, 32'h2);
    ver = 1'b1;
    wait_cyc(2);
    chk(clk_led[0], 32'h1);
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
